// ---- pwmdu_top.sv ----
// One PWM channel: duty source select, boundary or immediate duty update,
// output modes and override, with an APB register slave.
// Assumes one clock; the power stage is driven by the high and low outputs.
`timescale 1ns/1ns
module pwmdu_top #(
	parameter int DW = pwmdu_pkg::DUTY_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pwm_high,
	output logic pwm_low
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] time_base_control_reg_r;
	logic [15:0] generator_control_reg_r;
	logic [15:0] output_control_reg_r;
	logic [DW-1:0] channel_duty_reg_r;
	logic [DW-1:0] master_duty_reg_r;
	logic [DW-1:0] period_reg_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic pready_r;

	wire setup = psel & ~penable;
	wire access = psel & penable & pready_r;
	wire wr = access & pwrite;
	wire hit_tb = (paddr == pwmdu_pkg::OFF_TIME_BASE);
	wire hit_gc = (paddr == pwmdu_pkg::OFF_GEN_CTRL);
	wire hit_oc = (paddr == pwmdu_pkg::OFF_OUT_CTRL);
	wire hit_cd = (paddr == pwmdu_pkg::OFF_CHAN_DUTY);
	wire hit_md = (paddr == pwmdu_pkg::OFF_MASTER_DUTY);
	wire hit_pr = (paddr == pwmdu_pkg::OFF_PERIOD);
	wire hit_st = (paddr == pwmdu_pkg::OFF_STATUS);
	wire mapped = hit_tb | hit_gc | hit_oc | hit_cd | hit_md | hit_pr | hit_st;

	wire module_en = time_base_control_reg_r[pwmdu_pkg::TB_EN_BIT];
	wire imm_update = generator_control_reg_r[pwmdu_pkg::GC_IMM_BIT];
	wire src_master = generator_control_reg_r[pwmdu_pkg::GC_SRC_BIT];
	wire [1:0] mode = output_control_reg_r[pwmdu_pkg::OC_MODE_LO +: 2];
	wire ovr_h_en = output_control_reg_r[pwmdu_pkg::OC_OVRH_BIT];
	wire ovr_l_en = output_control_reg_r[pwmdu_pkg::OC_OVRL_BIT];
	wire [1:0] override_data_field = output_control_reg_r[pwmdu_pkg::OC_OVD_LO +: 2];
	wire ovr_sync_period = output_control_reg_r[pwmdu_pkg::OC_SYNC_BIT];

	// ----------------------------------------
	// Time base and duty path
	// ----------------------------------------
	logic [DW-1:0] count;
	logic boundary;
	logic [DW-1:0] active_period;
	logic [DW-1:0] active_duty;
	logic pp_phase_r;
	logic [1:0] ovr_en_r;
	logic [1:0] ovr_dat_r;
	logic pwm_high_r;
	logic pwm_low_r;

	pwmdu_counter #(.W(DW)) u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.en(module_en),
		.period(active_period),
		.count(count),
		.boundary(boundary)
	);

	pwmdu_sync_hold #(.W(DW), .RST(pwmdu_pkg::RST_PERIOD)) u_period (
		.pclk(pclk),
		.presetn(presetn),
		.immediate(~module_en),
		.boundary(boundary),
		.d(period_reg_r),
		.q(active_period)
	);

	// Source chosen before the hold, so a source flip also waits for the boundary unless immediate update is set
	wire [DW-1:0] selected_duty = src_master ? master_duty_reg_r : channel_duty_reg_r;

	// Disabled module loads straight through so the first period is clean
	pwmdu_sync_hold #(.W(DW), .RST(pwmdu_pkg::RST_DUTY)) u_duty (
		.pclk(pclk),
		.presetn(presetn),
		.immediate(imm_update | ~module_en),
		.boundary(boundary),
		.d(selected_duty),
		.q(active_duty)
	);

	// The comparison sees only the held duty, and a zero duty never compares
	// true, so no boundary glitch can form on any mode.
	wire raw_pwm = module_en & (count < active_duty);
	wire duty_zero = (active_duty == '0);

	// Push-pull toggles which pin carries the pulse each period
	wire pp_toggle = boundary & (mode == pwmdu_pkg::PWMDU_MODE_PUSHPULL);

	logic gen_h;
	logic gen_l;
	always_comb begin
		gen_h = 1'b0;
		gen_l = 1'b0;
		unique case (mode)
			pwmdu_pkg::PWMDU_MODE_REDUNDANT: begin
				gen_h = raw_pwm & ~duty_zero;
				gen_l = raw_pwm & ~duty_zero;
			end
			pwmdu_pkg::PWMDU_MODE_PUSHPULL: begin
				gen_h = raw_pwm & ~duty_zero & ~pp_phase_r;
				gen_l = raw_pwm & ~duty_zero & pp_phase_r;
			end
			pwmdu_pkg::PWMDU_MODE_COMP: begin
				gen_h = raw_pwm;
				gen_l = module_en & ~raw_pwm;
			end
			pwmdu_pkg::PWMDU_MODE_INDEP: begin
				gen_h = raw_pwm;
				gen_l = raw_pwm;
			end
		endcase
	end

	// Override capture: on the next clock, or at the boundary when sync is set and the module is enabled
	wire ovr_take = ~ovr_sync_period | boundary | ~module_en;

	wire out_h_nxt = ovr_en_r[1] ? ovr_dat_r[1] : gen_h;
	wire out_l_nxt = ovr_en_r[0] ? ovr_dat_r[0] : gen_l;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pp_phase_r <= 1'b0;
			ovr_en_r <= 2'b00;
			ovr_dat_r <= 2'b00;
			pwm_high_r <= 1'b0;
			pwm_low_r <= 1'b0;
		end else begin
			if (!module_en) begin
				pp_phase_r <= 1'b0;
			end else if (pp_toggle) begin
				pp_phase_r <= ~pp_phase_r;
			end
			if (ovr_take) begin
				ovr_en_r <= {ovr_h_en, ovr_l_en};
				ovr_dat_r <= override_data_field;
			end
			pwm_high_r <= out_h_nxt;
			pwm_low_r <= out_l_nxt;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire [31:0] status_word = {{(32 - DW - 3){1'b0}}, pp_phase_r, ovr_en_r[1], ovr_en_r[0], active_duty};
	wire [31:0] rd_mux =
		hit_tb ? {16'h0000, time_base_control_reg_r} :
		hit_gc ? {16'h0000, generator_control_reg_r} :
		hit_oc ? {16'h0000, output_control_reg_r} :
		hit_cd ? {{(32 - DW){1'b0}}, channel_duty_reg_r} :
		hit_md ? {{(32 - DW){1'b0}}, master_duty_reg_r} :
		hit_pr ? {{(32 - DW){1'b0}}, period_reg_r} :
		hit_st ? status_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			// No wait state: ready rises in the first access cycle
			pready_r <= setup;
			if (setup) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_r <= ~mapped;
			end
		end
	end

	// Status is read-only; writes to it are silently ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_base_control_reg_r <= 16'h0000;
			generator_control_reg_r <= 16'h0000;
			output_control_reg_r <= 16'h0000;
			channel_duty_reg_r <= pwmdu_pkg::RST_DUTY;
			master_duty_reg_r <= pwmdu_pkg::RST_DUTY;
			period_reg_r <= pwmdu_pkg::RST_PERIOD;
		end else if (wr) begin
			if (hit_tb) time_base_control_reg_r <= pwdata[15:0];
			if (hit_gc) generator_control_reg_r <= pwdata[15:0];
			if (hit_oc) output_control_reg_r <= pwdata[15:0];
			if (hit_cd) channel_duty_reg_r <= pwdata[DW-1:0];
			if (hit_md) master_duty_reg_r <= pwdata[DW-1:0];
			if (hit_pr) period_reg_r <= pwdata[DW-1:0];
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pwm_high = pwm_high_r;
	assign pwm_low = pwm_low_r;
endmodule

// ---- pwmdu_pkg.sv ----
// Package for the PWM duty-update and override channel.
// Assumes a 32-bit APB register bus and a single 100 MHz clock.
package pwmdu_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_TIME_BASE = 8'h00;
	localparam logic [7:0] OFF_GEN_CTRL = 8'h04;
	localparam logic [7:0] OFF_OUT_CTRL = 8'h08;
	localparam logic [7:0] OFF_CHAN_DUTY = 8'h0C;
	localparam logic [7:0] OFF_MASTER_DUTY = 8'h10;
	localparam logic [7:0] OFF_PERIOD = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TB_EN_BIT = 15;
	localparam int GC_IMM_BIT = 0;
	localparam int GC_SRC_BIT = 8;
	localparam int OC_SYNC_BIT = 0;
	localparam int OC_OVRL_BIT = 2;
	localparam int OC_OVRH_BIT = 3;
	localparam int OC_OVD_LO = 4;
	localparam int OC_MODE_LO = 10;
	// ----------------------------------------
	// Output modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		PWMDU_MODE_COMP = 2'b00,
		PWMDU_MODE_PUSHPULL = 2'b01,
		PWMDU_MODE_REDUNDANT = 2'b10,
		PWMDU_MODE_INDEP = 2'b11
	} pwmdu_mode_e;
	// ----------------------------------------
	// Reset values and duty width
	// ----------------------------------------
	localparam logic [15:0] RST_PERIOD = 16'h0063;
	localparam logic [15:0] RST_DUTY = 16'h0000;
	localparam int DUTY_W = 16;
endpackage

// ---- pwmdu_counter.sv ----
// Period counter of the time base with a boundary pulse.
// Assumes a period value held stable by the caller between boundaries.
`timescale 1ns/1ns
module pwmdu_counter #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic [W-1:0] period,
	output logic [W-1:0] count,
	output logic boundary
);
	wire wrap = (count >= period);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!en) begin
			count <= '0;
		end else if (wrap) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end
	// Boundary marks the last count of a period
	assign boundary = en & wrap;
endmodule

// ---- pwmdu_sync_hold.sv ----
// Holding register that loads either immediately or at a boundary.
// Assumes load strobes from the same clock domain.
`timescale 1ns/1ns
module pwmdu_sync_hold #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic immediate,
	input wire logic boundary,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	wire take = immediate | boundary;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else if (take) begin
			q <= d;
		end
	end
endmodule

// ---- pwmdu_top_props.sv ----
// Port checker for pwmdu_top: APB answer, output modes, overrides.
// Assumes binding to pwmdu_top, one clock, async active-low reset.
`timescale 1ns/1ns
module pwmdu_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pwm_high,
	input wire logic pwm_low
);
	// Shadow of the output control word, not visible at the ports
	logic [15:0] oc_r;
	wire oc_wr = psel && penable && pready && pwrite && paddr == 8'h08;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oc_r <= 16'h0000;
		else if (oc_wr)
			oc_r <= pwdata[15:0];
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ------------------------------
	// Assertions
	// ------------------------------
	apb_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
	apb_once_a: assert property (pready |=> !pready) else $error("pready held");
	apb_err_a: assert property (pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0) else $error("no error");
	redund_pair_a: assert property ((oc_r[11:10] == 2'b10 && oc_r[3:0] == 4'h0) [*4] |-> pwm_high == pwm_low)
		else $error("redundant pins differ");
	push_pull_a: assert property ((oc_r[11:10] == 2'b01 && oc_r[3:0] == 4'h0) [*4] |-> !(pwm_high && pwm_low))
		else $error("push-pull overlap");
	ovr_low_a: assert property (oc_wr && !pwdata[0] && pwdata[2] |-> ##3 pwm_low == $past(pwdata[4], 3))
		else $error("low override late");
	ovr_high_a: assert property (oc_wr && !pwdata[0] && pwdata[3] |-> ##3 pwm_high == $past(pwdata[5], 3))
		else $error("high override late");
	ovr_hold_a: assert property ((oc_r[2] && !oc_r[0] && $stable(oc_r)) [*3] |-> pwm_low == oc_r[4])
		else $error("low override lost");
endmodule
bind pwmdu_top pwmdu_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pwm_high(pwm_high), .pwm_low(pwm_low));

// ---- pwmdu_stage.sv ----
// Power stage model: counts turn-on events of each switch.
// Assumes registered gate drives from the PWM channel.
`timescale 1ns/1ns
module pwmdu_stage (
	input wire logic pclk,
	input wire logic hi,
	input wire logic lo,
	output int n_hi = 0,
	output int n_lo = 0
);
	logic ph = 1'b0;
	logic pl = 1'b0;
	always @(posedge pclk) begin
		n_hi <= n_hi + int'(hi && !ph);
		n_lo <= n_lo + int'(lo && !pl);
		ph <= hi;
		pl <= lo;
	end
endmodule

// ---- tb_pwmdu_top.sv ----
// Self-checking bench for the PWM channel over APB.
// Assumes the bound checker and the power stage model.
`timescale 1ns/1ns
module tb_pwmdu_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, pwm_high, pwm_low;
	int n_fail = 0;
	int samples_checked = 0;
	int n_hi, n_lo, h0, l0;
	pwmdu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_high(pwm_high), .pwm_low(pwm_low));
	pwmdu_stage stage (.pclk(pclk), .hi(pwm_high), .lo(pwm_low), .n_hi(n_hi), .n_lo(n_lo));
	initial forever #5 pclk = ~pclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready, data and error are all taken at the rising edge that samples ready high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic snap();
		h0 = n_hi;
		l0 = n_lo;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic s_regs();
		apb(1'b0, 8'h14, 32'h0);
		chk("period", 32'h63, rd);
		apb(1'b0, 8'h1C, 32'h0);
		chk("bad addr err", 32'h1, er);
		chk("bad addr data", 32'h0, rd);
	endtask
	task automatic s_cfg(input logic imm);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h14, 32'hF);
		apb(1'b1, 8'h04, {31'h0, imm});
		apb(1'b1, 8'h08, 32'h800);
		apb(1'b1, 8'h0C, 32'hC);
		apb(1'b1, 8'h00, 32'h8000);
		snap();
		cyc(40);
		chk("redundant", n_hi - h0, n_lo - l0);
		chk("pulses", 32'h1, n_hi > h0);
	endtask
	task automatic s_upd(input logic imm);
		@(posedge pwm_high);
		@(posedge pclk);
		apb(1'b1, 8'h0C, 32'h0);
		cyc(2);
		chk("duty hold", {31'h0, !imm}, pwm_high);
		snap();
		cyc(40);
		chk("zero duty", h0 + l0, n_hi + n_lo);
	endtask
	task automatic s_src();
		apb(1'b1, 8'h0C, 32'hC);
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h04, 32'h101);
		cyc(20);
		snap();
		cyc(40);
		chk("master zero", h0, n_hi);
		apb(1'b1, 8'h10, 32'hC);
		cyc(40);
		chk("master duty", 32'h1, n_hi > h0);
	endtask
	task automatic s_ovr();
		apb(1'b1, 8'h08, 32'h804);
		// Let the forced level reach the stage before counting starts
		cyc(2);
		snap();
		cyc(40);
		chk("low held", l0, n_lo);
		chk("high runs", 32'h1, n_hi > h0);
		apb(1'b1, 8'h08, 32'h814);
		cyc(2);
		chk("low forced", 32'h1, pwm_low);
		apb(1'b1, 8'h08, 32'h828);
		cyc(2);
		chk("high forced", 32'h1, pwm_high);
		apb(1'b1, 8'h08, 32'h800);
		snap();
		cyc(40);
		chk("low back", 32'h1, n_lo > l0);
	endtask
	task automatic s_sync();
		@(posedge pwm_high);
		@(posedge pclk);
		apb(1'b1, 8'h08, 32'h805);
		apb(1'b0, 8'h18, 32'h0);
		chk("sync wait", 32'hC, rd);
		cyc(12);
		apb(1'b0, 8'h18, 32'h0);
		chk("sync taken", 32'h1000C, rd);
		chk("sync low", 32'h0, pwm_low);
		apb(1'b1, 8'h08, 32'h800);
	endtask
	task automatic s_modes();
		apb(1'b1, 8'h08, 32'h000);
		cyc(2);
		snap();
		cyc(40);
		chk("comp high", 32'h1, n_hi > h0);
		chk("comp low", 32'h1, n_lo > l0);
		apb(1'b1, 8'h08, 32'hC00);
		cyc(2);
		snap();
		cyc(40);
		chk("indep pulses", 32'h1, n_hi > h0);
		chk("indep pair", n_hi - h0, n_lo - l0);
	endtask
	task automatic s_pp();
		apb(1'b1, 8'h08, 32'h400);
		snap();
		cyc(40);
		chk("pp high", 32'h1, n_hi > h0);
		chk("pp low", 32'h1, n_lo > l0);
	endtask
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_cfg(1'b0);
		s_upd(1'b0);
		s_cfg(1'b1);
		s_upd(1'b1);
		s_src();
		s_ovr();
		s_sync();
		s_modes();
		s_pp();
		finish_test();
	end
endmodule
